// ==== src/sic_map.vh ====
// register offsets, field positions and codes for the system integration control block
`ifndef SIC_MAP_VH
`define SIC_MAP_VH
`define SIC_OFF_SERVICE 8'h03
`define SIC_OFF_PIN_SEL 8'h04
`define SIC_OFF_PARK 8'h0c
`define SIC_OFF_CLKCTL 8'h08
`define SIC_SERVICE_FIRST 8'h55
`define SIC_SERVICE_SECOND 8'hAA
`define SIC_PARK_RESET 8'h00
`define SIC_CLKCTL_RESET 8'h00
`define SIC_PARK_HI 7
`define SIC_PARK_LO 6
`define SIC_IARB_BIT 5
`define SIC_EARB_BIT 4
`define SIC_SHOW_BIT 3
`define SIC_WIDE_COUNT_BIT 0
`define SIC_PARK_WMASK 8'hF9
`define SIC_STOPEN_BIT 7
`define SIC_WAKE_HI 2
`define SIC_WAKE_LO 0
`define SIC_CLKCTL_WMASK 8'h87
`define SIC_MODE_RR 2'b00
`define SIC_MODE_CORE 2'b01
`define SIC_MODE_DMA 2'b10
`define SIC_MODE_CUR 2'b11
`define SIC_WAKE_ANY 3'b000
`define SIC_WAKE_NONE 3'b111
`define SIC_BWC_MAX 3'b000
`define SIC_PIN_ALL_PORT 16'h0000
`define SIC_PIN_ALL_ALT 16'hFFFF
`define SIC_OWN_CORE 1'b0
`define SIC_OWN_DMA 1'b1
`endif

// ==== src/sic_arbiter.v ====
// internal bus arbiter between core, dma module and external master
`timescale 1ns/100ps
`include "sic_map.vh"
module sic_arbiter (
	// clock and reset
	input wire clk,
	input wire resetn,
	// configuration
	input wire [1:0] park_mode,
	input wire internal_arbitration_enable,
	input wire [2:0] dma_bandwidth_control,
	// requests
	input wire core_req,
	input wire dma_req,
	input wire external_bus_grant_n,
	// grants
	output reg grant_core,
	output reg grant_dma,
	output reg grant_ext
);
	reg last_owner;
	reg ext_return;
	reg next_core;
	reg next_dma;
	reg next_ext;
	always @* begin
		next_core = 1'b0;
		next_dma = 1'b0;
		next_ext = 1'b0;
		if (internal_arbitration_enable && external_bus_grant_n) begin
			next_ext = 1'b1; // R14
		end else if (ext_return && core_req) begin
			next_core = 1'b1;
		end else if (dma_req && dma_bandwidth_control == `SIC_BWC_MAX) begin
			next_dma = 1'b1; // R13
		end else if (core_req && dma_req) begin
			case (park_mode) // R11
				`SIC_MODE_RR: begin
					next_dma = (last_owner == `SIC_OWN_CORE); // R17
					next_core = (last_owner == `SIC_OWN_DMA); // R17
				end
				`SIC_MODE_CORE: begin
					next_core = 1'b1;
				end
				`SIC_MODE_DMA: begin
					next_dma = 1'b1;
				end
				`SIC_MODE_CUR: begin
					next_dma = (last_owner == `SIC_OWN_DMA);
					next_core = (last_owner == `SIC_OWN_CORE);
				end
				default: begin
					next_core = 1'b1;
				end
			endcase
		end else begin
			next_core = core_req;
			next_dma = dma_req;
		end
	end
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			grant_core <= 1'b0;
			grant_dma <= 1'b0;
			grant_ext <= 1'b0;
			last_owner <= `SIC_OWN_CORE;
			ext_return <= 1'b0;
		end else begin
			grant_core <= next_core;
			grant_dma <= next_dma;
			grant_ext <= next_ext;
			if (next_core) begin
				last_owner <= `SIC_OWN_CORE;
			end else if (next_dma) begin
				last_owner <= `SIC_OWN_DMA;
			end
			if (next_ext) begin
				ext_return <= 1'b1;
			end else if (next_core || next_dma) begin
				ext_return <= 1'b0;
			end
		end
	end
endmodule

// ==== src/sic_top.v ====
// system integration control: watchdog service, stop control, pin select, master park
// Functional notes
// R1 - software writes 55 then AA to service
// R2 - other accesses between service writes are tolerated
// R3 - service write never clears pending timeout
// R4 - acknowledge cycle clears watchdog pending flag
// R5 - stop acknowledged only with enable; reset clears
// R6 - stop gates only core clock
// R7 - wake level field sets wake priority threshold
// R8 - qualifying interrupt restores core clock
// R9 - pin bit zero port, one alternate
// R10 - pin select reset follows config pin
// R11 - park field selects internal arbitration scheme
// R12 - software enables internal arbitration for masters
// R13 - dma max bandwidth beats core; code grants a requesting core first after an external tenure ends
// R14 - negated external grant gives external priority
// R15 - external arbitration bit gates peripheral arbitration
// R16 - base address register is core only
// R17 - round robin alternates core and dma
// R18 - visibility with external arbitration drives data out
`timescale 1ns/100ps
`include "sic_map.vh"
module sic_top (
	// clock and reset
	input wire clk,
	input wire resetn,
	// register access
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_from_external,
	input wire reg_is_base_address,
	output reg [15:0] reg_rdata,
	output wire reg_base_denied,
	// watchdog
	input wire watchdog_timeout,
	input wire interrupt_acknowledge_cycle,
	output reg watchdog_pending_flag,
	output reg watchdog_serviced,
	// stop control
	input wire stop_request,
	input wire [2:0] interrupt_level,
	output reg stop_acknowledge,
	output wire core_clock_enable,
	output wire module_clock_enable,
	// pin function
	input wire addr_config_pin,
	output wire [15:0] pin_function_select,
	// arbitration
	input wire core_req,
	input wire dma_req,
	input wire [2:0] dma_bandwidth_control,
	input wire external_bus_grant_n,
	input wire peripheral_access,
	output wire grant_core,
	output wire grant_dma,
	output wire grant_ext,
	output wire peripheral_external_arbitrate,
	output wire register_data_drive_external,
	output wire dma_count_24bit
);
	////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] park_reg;
	reg [7:0] clkctl_reg;
	reg [15:0] pin_reg;
	reg pin_captured;
	reg service_armed;
	reg stopped;
	wire wr_ok;
	wire [2:0] wake_level_select;
	wire stop_acknowledge_enable;
	wire wake_hit;
	assign wr_ok = reg_wr && !(reg_is_base_address && reg_from_external); // R16
	assign reg_base_denied = (reg_wr || reg_rd) && reg_is_base_address && reg_from_external; // R16
	assign wake_level_select = clkctl_reg[`SIC_WAKE_HI:`SIC_WAKE_LO];
	assign stop_acknowledge_enable = clkctl_reg[`SIC_STOPEN_BIT];
	////////////////////////////////////////////////////////////////////////////
	// register writes
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			park_reg <= `SIC_PARK_RESET;
			clkctl_reg <= `SIC_CLKCTL_RESET; // R5
			pin_reg <= `SIC_PIN_ALL_PORT;
			pin_captured <= 1'b0;
		end else begin
			if (!pin_captured) begin
				pin_captured <= 1'b1;
				pin_reg <= addr_config_pin ? `SIC_PIN_ALL_ALT : `SIC_PIN_ALL_PORT; // R10
			end else if (wr_ok && reg_addr == `SIC_OFF_PIN_SEL) begin
				pin_reg <= reg_wdata; // R9
			end
			if (wr_ok && reg_addr == `SIC_OFF_PARK) begin
				park_reg <= reg_wdata[7:0] & `SIC_PARK_WMASK;
			end
			if (wr_ok && reg_addr == `SIC_OFF_CLKCTL) begin
				clkctl_reg <= reg_wdata[7:0] & `SIC_CLKCTL_WMASK;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// register reads
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd && !reg_base_denied) begin
			case (reg_addr)
				`SIC_OFF_PIN_SEL: begin
					reg_rdata <= pin_reg;
				end
				`SIC_OFF_PARK: begin
					reg_rdata <= {8'h00, park_reg};
				end
				`SIC_OFF_CLKCTL: begin
					reg_rdata <= {8'h00, clkctl_reg};
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// watchdog service and pending flag
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			service_armed <= 1'b0;
			watchdog_serviced <= 1'b0;
			watchdog_pending_flag <= 1'b0;
		end else begin
			watchdog_serviced <= 1'b0;
			if (wr_ok && reg_addr == `SIC_OFF_SERVICE) begin
				if (reg_wdata[7:0] == `SIC_SERVICE_FIRST) begin
					service_armed <= 1'b1; // R1
				end else if (reg_wdata[7:0] == `SIC_SERVICE_SECOND && service_armed) begin
					service_armed <= 1'b0;
					watchdog_serviced <= 1'b1; // R1
				end
				// other values leave the armed state alone R2
			end
			if (watchdog_timeout) begin
				watchdog_pending_flag <= 1'b1; // R3
			end else if (interrupt_acknowledge_cycle) begin
				watchdog_pending_flag <= 1'b0; // R4
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// stop mode and wake
	assign wake_hit = (wake_level_select == `SIC_WAKE_ANY) ? (interrupt_level != 3'b000) :
		(wake_level_select != `SIC_WAKE_NONE) && (interrupt_level > wake_level_select); // R7
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stopped <= 1'b0;
			stop_acknowledge <= 1'b0;
		end else begin
			stop_acknowledge <= 1'b0;
			if (stopped && wake_hit) begin
				stopped <= 1'b0; // R8
			end else if (!stopped && stop_request && stop_acknowledge_enable) begin
				stopped <= 1'b1; // R5
				stop_acknowledge <= 1'b1; // R5
			end
		end
	end
	assign core_clock_enable = !stopped; // R6
	assign module_clock_enable = 1'b1; // R6
	////////////////////////////////////////////////////////////////////////////
	// pin select and arbitration controls
	assign pin_function_select = pin_reg; // R9
	assign peripheral_external_arbitrate = peripheral_access && park_reg[`SIC_EARB_BIT] && !reg_is_base_address; // R15
	assign register_data_drive_external = park_reg[`SIC_SHOW_BIT] && park_reg[`SIC_EARB_BIT]; // R18
	assign dma_count_24bit = park_reg[`SIC_WIDE_COUNT_BIT];
	sic_arbiter u_arb (
		.clk(clk),
		.resetn(resetn),
		.park_mode(park_reg[`SIC_PARK_HI:`SIC_PARK_LO]), // R11
		.internal_arbitration_enable(park_reg[`SIC_IARB_BIT]), // R12
		.dma_bandwidth_control(dma_bandwidth_control),
		.core_req(core_req),
		.dma_req(dma_req),
		.external_bus_grant_n(external_bus_grant_n),
		.grant_core(grant_core),
		.grant_dma(grant_dma),
		.grant_ext(grant_ext)
	);
endmodule

// ==== testbench/sic_props.sv ====
// concurrent checks on the sic_top ports
`timescale 1ns/100ps
module sic_props (
	// watched ports
	input wire clk, input wire resetn, input wire reg_wr, input wire reg_rd,
	input wire [7:0] reg_addr, input wire [15:0] reg_wdata, input wire reg_from_external,
	input wire reg_is_base_address, input wire [15:0] reg_rdata, input wire reg_base_denied,
	input wire watchdog_timeout, input wire interrupt_acknowledge_cycle, input wire watchdog_pending_flag,
	input wire watchdog_serviced, input wire module_clock_enable, input wire core_req, input wire dma_req,
	input wire grant_core, input wire grant_dma, input wire grant_ext
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence svc_arm;
		reg_wr && reg_addr == 8'h03 && reg_wdata[7:0] == 8'h55;
	endsequence
	sequence svc_fire;
		reg_wr && reg_addr == 8'h03 && reg_wdata[7:0] == 8'hAA;
	endsequence
	svc_pair_a: assert property (svc_arm ##1 svc_fire |=> watchdog_serviced)
		else $error("service pair not honoured");
	pend_hold_a: assert property (watchdog_pending_flag && !interrupt_acknowledge_cycle |=> watchdog_pending_flag)
		else $error("pending flag lost");
	pend_set_a: assert property (watchdog_timeout |=> watchdog_pending_flag)
		else $error("pending flag not set");
	pend_clear_a: assert property (watchdog_pending_flag && interrupt_acknowledge_cycle && !watchdog_timeout
		|=> !watchdog_pending_flag)
		else $error("pending flag not cleared");
	module_clock_a: assert property (module_clock_enable)
		else $error("module clock gated");
	base_deny_a: assert property ((reg_wr || reg_rd) && reg_from_external && reg_is_base_address
		|-> reg_base_denied)
		else $error("base access not denied");
	base_read_a: assert property (reg_rd && reg_from_external && reg_is_base_address |=> reg_rdata == 16'h0000)
		else $error("base read leaked data");
	grant_excl_a: assert property ($onehot0({grant_core, grant_dma, grant_ext}))
		else $error("grants overlap");
	core_grant_a: assert property (grant_core |-> $past(core_req))
		else $error("core granted without request");
	dma_grant_a: assert property (grant_dma |-> $past(dma_req))
		else $error("dma granted without request");
endmodule
bind sic_top sic_props u_props (.*);

// ==== testbench/sic_partner.sv ====
// behavioural core, dma and external masters
`timescale 1ns/100ps
module sic_partner (
	// wishes from the bench
	input wire clk, input wire resetn, input wire core_want, input wire dma_want, input wire ext_want,
	// requests to the arbiter
	output logic core_req, output logic dma_req, output logic external_bus_grant_n
);
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_req <= 1'b0;
			dma_req <= 1'b0;
			external_bus_grant_n <= 1'b0;
		end else begin
			core_req <= core_want;
			dma_req <= dma_want;
			external_bus_grant_n <= ext_want;
		end
	end
endmodule

// ==== testbench/system_integration_control_tb.sv ====
// self-checking bench for sic_top
`timescale 1ns/100ps
module system_integration_control_tb;
	logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_from_external = 0, reg_is_base_address = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, pin_function_select;
	logic watchdog_timeout = 0, interrupt_acknowledge_cycle = 0, stop_request = 0, addr_config_pin = 0;
	logic [2:0] interrupt_level = 3'h0, dma_bandwidth_control = 3'h2;
	logic core_want = 0, dma_want = 0, ext_want = 0, peripheral_access = 0;
	logic core_req, dma_req, external_bus_grant_n, reg_base_denied, watchdog_pending_flag, watchdog_serviced;
	logic stop_acknowledge, core_clock_enable, module_clock_enable, grant_core, grant_dma, grant_ext;
	logic peripheral_external_arbitrate, register_data_drive_external, dma_count_24bit;
	int err_count = 0, check_count = 0;
	always #5 clk = ~clk;
	sic_top uut (.*);
	sic_partner masters (.*);
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task test_done;
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(negedge clk);
	endtask
	task rd(input string name, input logic [7:0] a, input logic [15:0] exp);
		acc(0, 1, a, 16'h0000);
		acc(0, 0, 8'h00, 16'h0000);
		chk(name, reg_rdata, exp);
	endtask
	task automatic waitv(input string name, input logic sel, input logic v);
		int n;
		n = 0;
		while (n < 50 && (sel ? grant_ext : core_clock_enable) !== v) begin
			@(negedge clk);
			n++;
		end
		chk(name, sel ? grant_ext : core_clock_enable, v);
		if ((sel ? grant_ext : core_clock_enable) !== v) test_done;
	endtask
	task t_pins;
		chk("pins", pin_function_select, 16'h0000);
		rd("park", 8'h0c, 16'h0000);
		rd("clkctl", 8'h08, 16'h0000);
		acc(1, 0, 8'h04, 16'h5a3c);
		acc(0, 0, 8'h00, 16'h0000);
		chk("pins", pin_function_select, 16'h5a3c);
		@(posedge clk);
		addr_config_pin <= 1'b1;
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		chk("pins", pin_function_select, 16'hffff);
	endtask
	task t_dog;
		acc(1, 0, 8'h03, 16'h0055);
		acc(1, 0, 8'h03, 16'h0012);
		acc(0, 1, 8'h0c, 16'h0000);
		acc(1, 0, 8'h03, 16'h00aa);
		acc(0, 0, 8'h00, 16'h0000);
		chk("serviced", watchdog_serviced, 1'b1);
		@(posedge clk);
		watchdog_timeout <= 1'b1;
		@(posedge clk);
		watchdog_timeout <= 1'b0;
		acc(1, 0, 8'h03, 16'h0055);
		acc(1, 0, 8'h03, 16'h00aa);
		acc(0, 0, 8'h00, 16'h0000);
		chk("pending", watchdog_pending_flag, 1'b1);
		@(posedge clk);
		interrupt_acknowledge_cycle <= 1'b1;
		@(posedge clk);
		interrupt_acknowledge_cycle <= 1'b0;
		@(negedge clk);
		chk("pending", watchdog_pending_flag, 1'b0);
	endtask
	task t_stop;
		@(posedge clk);
		stop_request <= 1'b1;
		repeat (4) @(negedge clk);
		chk("core_clk", core_clock_enable, 1'b1);
		@(posedge clk);
		stop_request <= 1'b0;
		acc(1, 0, 8'h08, 16'h00ff);
		rd("clkctl", 8'h08, 16'h0087);
		@(posedge clk);
		stop_request <= 1'b1;
		interrupt_level <= 3'h7;
		waitv("core_clk", 1'b0, 1'b0);
		chk("stop_ack", stop_acknowledge, 1'b1);
		repeat (4) @(negedge clk);
		chk("core_clk", core_clock_enable, 1'b0);
		@(posedge clk);
		interrupt_level <= 3'h3;
		acc(1, 0, 8'h08, 16'h0083);
		repeat (4) @(negedge clk);
		chk("core_clk", core_clock_enable, 1'b0);
		@(posedge clk);
		interrupt_level <= 3'h4;
		stop_request <= 1'b0;
		waitv("core_clk", 1'b0, 1'b1);
	endtask
	task t_arb;
		logic g;
		acc(1, 0, 8'h0c, 16'h0020);
		@(posedge clk);
		{ext_want, core_want, dma_want, peripheral_access} <= 4'hf;
		waitv("ext", 1'b1, 1'b1);
		@(posedge clk);
		ext_want <= 1'b0;
		repeat (4) @(negedge clk);
		g = grant_core;
		@(negedge clk);
		chk("rr", {grant_core, grant_dma}, {~g, g});
		@(posedge clk);
		dma_bandwidth_control <= 3'h0;
		repeat (2) begin
			repeat (2) @(negedge clk);
			chk("bwc", {grant_core, grant_dma}, 2'b01);
		end
		@(posedge clk);
		dma_bandwidth_control <= 3'h2;
		for (int m = 1; m < 4; m++) begin
			acc(1, 0, 8'h0c, {8'h00, m[1:0], 6'h20});
			repeat (3) @(negedge clk);
			chk("park", {grant_core, grant_dma}, m == 1 ? 2'b10 : 2'b01);
		end
		for (int v = 0; v < 2; v++) begin
			acc(1, 0, 8'h0c, v ? 16'h0018 : 16'h0008);
			acc(0, 0, 8'h00, 16'h0000);
			chk("show", register_data_drive_external, v[0]);
			chk("earb", peripheral_external_arbitrate, v[0]);
			chk("wide_count", dma_count_24bit, 1'b0);
		end
		acc(1, 0, 8'h0c, 16'h00ff);
		rd("park", 8'h0c, 16'h00f9);
		chk("wide_count", dma_count_24bit, 1'b1);
		@(posedge clk);
		{reg_from_external, reg_is_base_address} <= 2'b11;
		acc(1, 0, 8'h0c, 16'h0000);
		chk("denied", reg_base_denied, 1'b1);
		rd("base", 8'h0c, 16'h0000);
		@(posedge clk);
		{reg_from_external, reg_is_base_address} <= 2'b00;
		rd("park", 8'h0c, 16'h00f9);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		t_pins;
		t_dog;
		t_stop;
		t_arb;
		test_done;
	end
endmodule
